// >>> src/fc_nsp_pkg.sv
// shared constants of the fibre channel native service processor
// assumes a 66-bit word lane per core_clk cycle and a classic wishbone host
package fc_nsp_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR       = 8'h00;
  localparam logic [7:0] STATUS_ADDR     = 8'h04;
  localparam logic [7:0] REPLACE_CNT_ADDR = 8'h08;
  localparam logic [7:0] NOS_CNT_ADDR    = 8'h0C;

  // control field positions and reset values
  localparam int CTRL_RATE_LSB  = 0;
  localparam int CTRL_FEC16_BIT = 3;
  localparam int CTRL_SCR8_BIT  = 4;
  localparam int CTRL_EN_BIT    = 5;
  localparam logic [2:0] RATE_RESET  = 3'h0;
  localparam logic       FEC16_RESET = 1'b0;
  localparam logic       SCR8_RESET  = 1'b0;
  localparam logic       EN_RESET    = 1'b0;

  // configured client rate codes
  localparam logic [2:0] RATE_1G   = 3'h0;
  localparam logic [2:0] RATE_2G   = 3'h1;
  localparam logic [2:0] RATE_4G   = 3'h2;
  localparam logic [2:0] RATE_8G   = 3'h3;
  localparam logic [2:0] RATE_16G  = 3'h4;
  localparam logic [2:0] RATE_32G  = 3'h5;
  localparam logic [2:0] RATE_64G  = 3'h6;
  localparam logic [2:0] RATE_128G = 3'h7;

  // ---------------------------------------------------------------
  // word sync thresholds
  // ---------------------------------------------------------------
  localparam logic [6:0] SYNC_GOOD_CNT = 7'h40;
  localparam logic [6:0] SYNC_BAD_CNT  = 7'h10;

  // ---------------------------------------------------------------
  // code words
  // ---------------------------------------------------------------
  localparam int          BITS_8B10B  = 40;
  localparam int          BITS_64B66B = 64;
  localparam logic [1:0]  HDR_DATA    = 2'h2;
  localparam logic [1:0]  HDR_CTRL    = 2'h1;
  localparam logic [9:0]  K30_7_CHAR  = 10'h1E8;
  localparam logic [39:0] NOS_WORD_8B = 40'hAA_95AB_9A96;
  localparam logic [63:0] ERR_BLOCK   = {{8{7'h1E}}, 8'h1E};
  localparam logic [63:0] NOS_BLOCK   = 64'h0000_0000_0000_004B;
  localparam logic [57:0] SCR_SEED    = 58'h3FF_FFFF_FFFF_FFFF;

endpackage : fc_nsp_pkg

// >>> src/fc_nsp.sv
// fibre channel native service processor for a bit-stream pseudowire
// assumes client words arrive word-aligned on core_clk; fec, transcoding
// and alignment-marker cores sit outside and are steered by this block
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps

module fc_nsp (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // wishbone slave
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  // client receive side
  input  wire logic [65:0] clientRxWord,
  input  wire logic        clientRxValid,
  input  wire logic        clientSignalDetect,
  // decoded stream back from the external fec decoder and transcoder
  input  wire logic [65:0] fecRxWord,
  input  wire logic        fecRxValid,
  // toward the packet-side interworking function
  output logic      [65:0] netWord,
  output logic             netValid,
  output logic             netFault,
  // from the packet-side interworking function
  input  wire logic [65:0] iwfWord,
  input  wire logic        iwfValid,
  input  wire logic        packetLossState,
  input  wire logic        iwfFaultFlag,
  // client transmit side
  output logic      [65:0] clientTxWord,
  output logic             clientTxValid,
  // steering of external coding cores
  output logic             fecDecodeEn,
  output logic             fecEncodeEn,
  output logic             transcodeEn,
  output logic             alignMarkerEn,
  output logic             txScrambleAfterFecEn,
  output logic             ttsFecAdvertise
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------

  // self-synchronous x^58+x^39+1; descr feeds line bits into the state
  function automatic logic [121:0] scramble(input logic [57:0] st,
                                            input logic [63:0] d,
                                            input logic        descr,
                                            input logic        short8);
    logic [63:0] o;
    logic [57:0] s;
    logic        b;
    o = d;
    s = st;
    b = 1'b0;
    for (int i = 0; i < fc_nsp_pkg::BITS_64B66B; i++)
    begin
      if (!short8 || i < fc_nsp_pkg::BITS_8B10B)
      begin
        b    = d[i] ^ s[38] ^ s[57];
        o[i] = b;
        s    = {s[56:0], descr ? d[i] : b};
      end
    end
    return {s, o};
  endfunction : scramble

  // a 10b character is legal only with four to six ones; coarse, no disparity tracking
  function automatic logic charValid(input logic [9:0] c);
    return ($countones(c) >= 4) && ($countones(c) <= 6);
  endfunction : charValid

  // transmission word check: all four characters for 8b10b, only the sync header for 64b66b
  function automatic logic wordValid(input logic [65:0] w, input logic is8b);
    if (is8b)
      return charValid(w[9:0]) && charValid(w[19:10]) &&
             charValid(w[29:20]) && charValid(w[39:30]);
    else
      return (w[1:0] == fc_nsp_pkg::HDR_DATA) || (w[1:0] == fc_nsp_pkg::HDR_CTRL);
  endfunction : wordValid

  // payload bits that the scrambler sees
  function automatic logic [63:0] payloadOf(input logic [65:0] w, input logic is8b);
    return is8b ? {24'h0, w[39:0]} : w[65:2];
  endfunction : payloadOf

  // rebuild a lane word from payload and header
  function automatic logic [65:0] wordOf(input logic [63:0] p, input logic [1:0] h,
                                         input logic is8b);
    return is8b ? {26'h0, p[39:0]} : {p, h};
  endfunction : wordOf

  // sync hunt: lock after a run of good words, drop after a run of bad
  function automatic logic [7:0] syncNext(input logic       locked,
                                          input logic [6:0] cnt,
                                          input logic       valid,
                                          input logic       good);
    logic [6:0] n;
    n = (locked == good) ? 7'h0 : cnt + 7'h1;
    if (!valid)
      return {locked, cnt};
    if (n == (locked ? fc_nsp_pkg::SYNC_BAD_CNT : fc_nsp_pkg::SYNC_GOOD_CNT))
      return {!locked, 7'h0};
    return {locked, n};
  endfunction : syncNext

  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  logic [2:0]  rate_q;
  logic        fec16En_q;
  logic        scr8En_q;
  logic        enable_q;
  logic        wbAck_q;
  logic [31:0] wbDat_q;
  logic [31:0] replaceCnt_q;
  logic [31:0] nosCnt_q;
  logic        sdMeta_q;
  logic        sdSync_q;
  logic        netLocked_q;
  logic [6:0]  netCnt_q;
  logic        cliLocked_q;
  logic [6:0]  cliCnt_q;
  logic [57:0] netScr_q;
  logic [57:0] cliDscr_q;
  logic [57:0] cliScr_q;
  logic [65:0] netWord_q;
  logic        netValid_q;
  logic        netFault_q;
  logic [65:0] cliWord_q;
  logic        cliValid_q;

  // ---------------------------------------------------------------
  // rate decode
  // ---------------------------------------------------------------
  // the rate is only ever what software wrote; nothing here negotiates
  wire is8b        = (rate_q <= fc_nsp_pkg::RATE_8G);
  wire rate16      = (rate_q == fc_nsp_pkg::RATE_16G);
  wire rate64      = (rate_q == fc_nsp_pkg::RATE_64G);
  wire fecMand     = (rate_q >= fc_nsp_pkg::RATE_32G);
  wire fecActive   = fecMand || (rate16 && fec16En_q);
  wire cliScrOn    = rate16 || ((rate_q == fc_nsp_pkg::RATE_8G) && scr8En_q);

  // steering for the external cores
  assign fecDecodeEn          = enable_q && fecActive;
  assign fecEncodeEn          = enable_q && fecActive;
  assign transcodeEn          = enable_q && fecMand;
  assign alignMarkerEn        = enable_q && rate64;
  assign txScrambleAfterFecEn = enable_q && fecMand && !rate64;
  assign ttsFecAdvertise      = fecActive;

  // ---------------------------------------------------------------
  // network-bound path
  // ---------------------------------------------------------------
  // rates from 32G up take the stream recovered by the decoder, others (16G with fec too) the raw lane
  wire [65:0]  netSrcWord  = fecMand ? fecRxWord : clientRxWord;
  wire         netSrcValid = enable_q && (fecMand ? fecRxValid : clientRxValid);
  wire         netGood     = wordValid(clientRxWord, is8b);
  wire [7:0]   netSyncNx   = syncNext(netLocked_q, netCnt_q,
                                      enable_q && clientRxValid, netGood);
  wire [121:0] netScrOut   = scramble(netScr_q, fecRxWord[65:2], 1'b0, 1'b0);
  wire [65:0]  netOut      = fecMand ? {netScrOut[63:0], fecRxWord[1:0]}
                                     : netSrcWord;
  wire         clientFault = !sdSync_q || !netLocked_q;

  // outgoing words and fault toward the interworking function
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sdMeta_q   <= 1'b0;
      sdSync_q   <= 1'b0;
      netScr_q   <= fc_nsp_pkg::SCR_SEED;
      netWord_q  <= 66'h0;
      netValid_q <= 1'b0;
      netFault_q <= 1'b1;
    end
    else
    begin
      if (netSrcValid && fecMand)
        netScr_q <= netScrOut[121:64];
      if (netSrcValid)
        netWord_q <= netOut;
      netValid_q <= netSrcValid;
      netFault_q <= clientFault;
      sdMeta_q   <= clientSignalDetect; // optics pin: two flops before use
      sdSync_q   <= sdMeta_q;
    end
  end

  assign netWord  = netWord_q;
  assign netValid = netValid_q;
  assign netFault = netFault_q;

  // ---------------------------------------------------------------
  // client-bound path
  // ---------------------------------------------------------------
  // descramble before checking so replacement sees plain characters
  wire         cliValid   = enable_q && iwfValid;
  wire [121:0] cliDscrOut = scramble(cliDscr_q, payloadOf(iwfWord, is8b), 1'b1, is8b);
  wire [63:0]  cliPlain   = cliScrOn ? cliDscrOut[63:0]
                                     : payloadOf(iwfWord, is8b);
  wire [65:0]  cliRebuilt = wordOf(cliPlain, iwfWord[1:0], is8b);
  wire         cliGood    = wordValid(cliRebuilt, is8b);
  wire [7:0]   cliSyncNx  = syncNext(cliLocked_q, cliCnt_q, cliValid, cliGood);
  wire [65:0]  replWord   = is8b ? {26'h0, {4{fc_nsp_pkg::K30_7_CHAR}}}
                                 : {fc_nsp_pkg::ERR_BLOCK, fc_nsp_pkg::HDR_CTRL};
  wire         doReplace  = !cliGood;
  wire [65:0]  fixedWord  = doReplace ? replWord : cliRebuilt;
  wire         doNos      = packetLossState || iwfFaultFlag;
  wire [65:0]  nosWord    = is8b ? {26'h0, fc_nsp_pkg::NOS_WORD_8B}
                                 : {fc_nsp_pkg::NOS_BLOCK, fc_nsp_pkg::HDR_CTRL};
  wire [65:0]  finalWord  = doNos ? nosWord : fixedWord;
  wire [121:0] cliScrOut  = scramble(cliScr_q, payloadOf(finalWord, is8b), 1'b0, is8b);
  wire [65:0]  txWord     = cliScrOn ? wordOf(cliScrOut[63:0], finalWord[1:0], is8b)
                                     : finalWord;

  // word sync on both lanes; held in hunt while disabled
  always_ff @(posedge core_clk)
  begin
    if (srst || !enable_q)
    begin
      netLocked_q <= 1'b0;
      netCnt_q    <= 7'h0;
      cliLocked_q <= 1'b0;
      cliCnt_q    <= 7'h0;
    end
    else
    begin
      netLocked_q <= netSyncNx[7];
      netCnt_q    <= netSyncNx[6:0];
      cliLocked_q <= cliSyncNx[7];
      cliCnt_q    <= cliSyncNx[6:0];
    end
  end

  // scrambler states advance only on accepted words
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      cliDscr_q  <= fc_nsp_pkg::SCR_SEED;
      cliScr_q   <= fc_nsp_pkg::SCR_SEED;
      cliWord_q  <= 66'h0;
      cliValid_q <= 1'b0;
    end
    else
    begin
      if (cliValid && cliScrOn)
      begin
        cliDscr_q <= cliDscrOut[121:64];
        cliScr_q  <= cliScrOut[121:64];
      end
      if (cliValid)
        cliWord_q <= txWord;
      cliValid_q <= cliValid;
    end
  end

  assign clientTxWord  = cliWord_q;
  assign clientTxValid = cliValid_q;

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  // one wait state: ack rises the cycle after the request appears
  wire wbReq      = wb_cyc_i && wb_stb_i && !wbAck_q;
  wire wbWr       = wbReq && wb_we_i;
  wire hitCtrl    = (wb_adr_i == fc_nsp_pkg::CTRL_ADDR);
  wire hitStatus  = (wb_adr_i == fc_nsp_pkg::STATUS_ADDR);
  wire hitReplace = (wb_adr_i == fc_nsp_pkg::REPLACE_CNT_ADDR);
  wire hitNos     = (wb_adr_i == fc_nsp_pkg::NOS_CNT_ADDR);
  wire [31:0] ctrlView   = {26'h0, enable_q, scr8En_q, fec16En_q, rate_q};
  wire [31:0] statusView = {25'h0, fecActive, iwfFaultFlag, packetLossState,
                            netFault_q, cliLocked_q, netLocked_q, !sdSync_q};
  wire [31:0] readMux    = hitCtrl    ? ctrlView :
                           hitStatus  ? statusView :
                           hitReplace ? replaceCnt_q :
                           hitNos     ? nosCnt_q : 32'h0;
  wire clrReplace = wbWr && hitReplace;
  wire clrNos     = wbWr && hitNos;
  wire incReplace = cliValid && doReplace && !doNos;
  wire incNos     = cliValid && doNos;
  wire [31:0] replaceNx = (clrReplace ? 32'h0 : replaceCnt_q) + {31'h0, incReplace};
  wire [31:0] nosNx     = (clrNos ? 32'h0 : nosCnt_q) + {31'h0, incNos};

  // control register, only byte lane 0 carries fields
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rate_q    <= fc_nsp_pkg::RATE_RESET;
      fec16En_q <= fc_nsp_pkg::FEC16_RESET;
      scr8En_q  <= fc_nsp_pkg::SCR8_RESET;
      enable_q  <= fc_nsp_pkg::EN_RESET;
    end
    else if (wbWr && hitCtrl && wb_sel_i[0])
    begin
      rate_q    <= wb_dat_i[fc_nsp_pkg::CTRL_RATE_LSB +: 3];
      fec16En_q <= wb_dat_i[fc_nsp_pkg::CTRL_FEC16_BIT];
      scr8En_q  <= wb_dat_i[fc_nsp_pkg::CTRL_SCR8_BIT];
      enable_q  <= wb_dat_i[fc_nsp_pkg::CTRL_EN_BIT];
    end
  end

  // ack and read data; unmapped reads answer zero
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      wbAck_q <= 1'b0;
      wbDat_q <= 32'h0;
    end
    else
    begin
      wbAck_q <= wbReq;
      if (wbReq)
        wbDat_q <= readMux;
    end
  end

  // event counters; a count in the clearing cycle is kept
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      replaceCnt_q <= 32'h0;
      nosCnt_q     <= 32'h0;
    end
    else
    begin
      replaceCnt_q <= replaceNx;
      nosCnt_q     <= nosNx;
    end
  end

  assign wb_ack_o = wbAck_q;
  assign wb_dat_o = wbDat_q;

endmodule : fc_nsp

// >>> verif/fc_nsp_chk.sv
// port checker for the fibre channel native service processor
// assumes it is bound to fc_nsp and sees only that module's ports
`timescale 1ns/1ps
module fc_nsp_chk (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        srst,
  // host bus
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  // streams
  input wire logic [65:0] clientRxWord,
  input wire logic        clientRxValid,
  input wire logic        clientSignalDetect,
  input wire logic [65:0] fecRxWord,
  input wire logic        fecRxValid,
  input wire logic [65:0] netWord,
  input wire logic        netValid,
  input wire logic        netFault,
  input wire logic [65:0] iwfWord,
  input wire logic        iwfValid,
  input wire logic        packetLossState,
  input wire logic        iwfFaultFlag,
  input wire logic [65:0] clientTxWord,
  input wire logic        clientTxValid,
  // coding core steering
  input wire logic        fecDecodeEn,
  input wire logic        fecEncodeEn,
  input wire logic        transcodeEn,
  input wire logic        alignMarkerEn,
  input wire logic        txScrambleAfterFecEn,
  input wire logic        ttsFecAdvertise
);
  logic [5:0] shadowCtrl_q;
  // ----------------------------------------------------------------
  // control shadow, updated on the same edge the write is taken
  // ----------------------------------------------------------------
  wire       wrCtrl  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
                       && wb_adr_i == fc_nsp_pkg::CTRL_ADDR;
  wire       en      = shadowCtrl_q[5];
  wire       fec16   = shadowCtrl_q[3];
  wire [2:0] rate    = shadowCtrl_q[2:0];
  wire       plain8b = rate < fc_nsp_pkg::RATE_8G || (rate == fc_nsp_pkg::RATE_8G && !shadowCtrl_q[4]);
  wire       nosReq  = packetLossState || iwfFaultFlag;
  always_ff @(posedge core_clk)
    if (srst) shadowCtrl_q <= 6'h00;
    else if (wrCtrl) shadowCtrl_q <= wb_dat_i[5:0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_net_passthrough: assert property (
    en && rate < fc_nsp_pkg::RATE_32G && clientRxValid |=> netValid && netWord == $past(clientRxWord))
    else $error("client word not passed unchanged");
  a_net_fec_path: assert property (
    en && rate >= fc_nsp_pkg::RATE_32G && fecRxValid |=> netValid && netWord[1:0] == $past(fecRxWord[1:0]))
    else $error("decoded word not forwarded");
  a_idle_quiet: assert property (!en |=> !netValid && !clientTxValid)
    else $error("output while disabled");
  a_fault_on_los: assert property (!clientSignalDetect [*4] |=> netFault)
    else $error("signal loss not flagged");
  a_k30_replace: assert property (
    en && plain8b && iwfValid && !nosReq && iwfWord[9:0] == 10'h000
    |=> clientTxWord[39:0] == {4{fc_nsp_pkg::K30_7_CHAR}})
    else $error("invalid word not replaced");
  a_nos_insert_8b: assert property (
    en && plain8b && iwfValid && nosReq |=> clientTxValid && clientTxWord[39:0] == fc_nsp_pkg::NOS_WORD_8B)
    else $error("not operational set missing");
  a_err_header_66: assert property (
    en && rate == fc_nsp_pkg::RATE_16G && iwfValid && !nosReq && iwfWord[1:0] == 2'h3
    |=> clientTxWord[1:0] == fc_nsp_pkg::HDR_CTRL)
    else $error("bad header not replaced");
  a_fec_mandatory: assert property (
    en && rate >= fc_nsp_pkg::RATE_32G |-> fecDecodeEn && fecEncodeEn && transcodeEn)
    else $error("fec path off at high rate");
  a_fec16_optional: assert property (rate == fc_nsp_pkg::RATE_16G
    |-> ttsFecAdvertise == fec16 && (!en || fecDecodeEn == fec16))
    else $error("optional fec steering wrong");
  a_marker_64g: assert property (en |-> alignMarkerEn == (rate == fc_nsp_pkg::RATE_64G))
    else $error("marker steering wrong");
  a_scramble_fec: assert property (en |-> txScrambleAfterFecEn ==
    (rate == fc_nsp_pkg::RATE_32G || rate == fc_nsp_pkg::RATE_128G))
    else $error("post fec scrambling steering wrong");
  // main scenarios reached
  c_nos_request: cover property (en && iwfValid && nosReq);
  c_sync_gained: cover property ($fell(netFault));
  c_bus_read: cover property (wb_ack_o && !wb_we_i);
endmodule : fc_nsp_chk

// >>> verif/fc_client_model.sv
// stand-in for the client port: word lane and light detect
// assumes one word per core_clk; the bench steers run, coding and light
`timescale 1ns/1ps
module fc_client_model (
  // control
  input  wire logic        core_clk,
  input  wire logic        run,
  input  wire logic        mode66,
  input  wire logic        lightOff,
  // client lane
  output logic      [65:0] clientRxWord,
  output logic             clientRxValid,
  output logic             clientSignalDetect
);
  // five ones per char keeps every char a legal code group
  function automatic logic [9:0] balChar();
    logic [4:0] r;
    r = 5'($urandom());
    return {r, ~r};
  endfunction : balChar
  initial
  begin
    clientRxWord       = 66'h0;
    clientRxValid      = 1'b0;
    clientSignalDetect = 1'b1;
  end
  // fixed coding chosen by the bench, never negotiated
  always @(posedge core_clk)
  begin
    clientRxValid      <= run;
    clientSignalDetect <= !lightOff;
    if (!run)
      clientRxWord <= ~clientRxWord; // idle lane toggles, never holds data
    else if (mode66)
      clientRxWord <= {$urandom(), $urandom(), fc_nsp_pkg::HDR_DATA};
    else
      clientRxWord <= {26'($urandom()), balChar(), balChar(), balChar(), balChar()};
  end
endmodule : fc_client_model

// >>> verif/tb.sv
// self-checking bench for fc_nsp with a client model and queued notes
// assumes 100 MHz core_clk and the classic wishbone map of the package
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic [65:0] v; logic [65:0] m;} note_t;
  logic        core_clk, srst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, seed;
  logic [3:0]  wb_sel_i;
  logic [65:0] clientRxWord, fecRxWord, netWord, iwfWord, clientTxWord, w, e;
  logic        clientRxValid, clientSignalDetect, fecRxValid, netValid, netFault;
  logic        iwfValid, packetLossState, iwfFaultFlag, clientTxValid;
  logic        run, mode66, lightOff, enTb;
  logic [2:0]  rateTb;
  int          miscompares, testsRun, cycles;
  note_t       netQ[$], txQ[$], rdQ[$];
  // ----------------------------------------------------------------
  // design and client model
  // ----------------------------------------------------------------
  fc_nsp i_fc_nsp (.*, .fecDecodeEn(), .fecEncodeEn(), .transcodeEn(), .alignMarkerEn(),
    .txScrambleAfterFecEn(), .ttsFecAdvertise());
  fc_client_model i_fc_client_model (.*);
  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic check(input logic [65:0] seen, input logic [65:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic take(ref note_t q[$], input logic [65:0] seen);
    note_t n;
    n = (q.size() > 0) ? q.pop_front() : note_t'{~seen, '1}; // empty queue never matches
    check(seen & n.m, n.v & n.m);
  endtask : take
  task automatic stop_test();
    $display("compares %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // ----------------------------------------------------------------
  // bus and stream drivers
  // ----------------------------------------------------------------
  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
    wb_adr_i <= a;
    wb_we_i  <= we;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    while (wb_ack_o !== 1'b1) @(posedge core_clk); // ends on ack; the hang guard stops the run if none comes
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    rdQ.push_back(note_t'{66'(v), 66'(m)});
    wb(a, 1'b0, 32'h0);
  endtask : rd
  task automatic send(input logic [65:0] d, input logic pls, input logic flg,
                      input logic [65:0] exp, input logic [65:0] m);
    iwfWord         <= d;
    iwfValid        <= 1'b1;
    packetLossState <= pls;
    iwfFaultFlag    <= flg;
    txQ.push_back(note_t'{exp, m});
    @(posedge core_clk);
  endtask : send
  task automatic endTest(input string name);
    iwfValid        <= 1'b0;
    packetLossState <= 1'b0;
    iwfFaultFlag    <= 1'b0;
    iwfWord         <= ~iwfWord; // released lane shows no stale word
    repeat (4) @(posedge core_clk);
    $display("test %s done", name);
  endtask : endTest
  // clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // notes for the network side, taken where the design takes its words
  always @(posedge core_clk)
  begin
    if (enTb && rateTb < fc_nsp_pkg::RATE_32G && clientRxValid)
      netQ.push_back(note_t'{clientRxWord, '1});
    if (enTb && rateTb >= fc_nsp_pkg::RATE_32G && fecRxValid)
      netQ.push_back(note_t'{fecRxWord, 66'h3});
  end
  // results taken oldest first; also the hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (!srst && netValid) take(netQ, netWord);
    if (!srst && clientTxValid) take(txQ, clientTxWord);
    if (!srst && wb_ack_o && !wb_we_i) take(rdQ, 66'(wb_dat_o));
    if (cycles == 5000)
    begin
      miscompares++;
      stop_test();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {wb_we_i, wb_cyc_i, wb_stb_i, fecRxValid, iwfValid, packetLossState} = 6'h00;
    {iwfFaultFlag, run, mode66, lightOff, enTb} = 5'h00;
    {wb_adr_i, wb_dat_i, wb_sel_i, rateTb, fecRxWord, iwfWord} = '0;
    {miscompares, testsRun, cycles} = '0;
    seed = $urandom(32'h4F4BCDBD);
    srst = 1'b1;
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rd(fc_nsp_pkg::CTRL_ADDR, 32'h0, 32'h3F);
    rd(fc_nsp_pkg::STATUS_ADDR, 32'h08, 32'h08);
    wb(8'h10, 1'b1, 32'hFFFFFFFF);
    rd(8'h10, 32'h0, 32'hFFFFFFFF);
    rd(fc_nsp_pkg::CTRL_ADDR, 32'h0, 32'h3F);
    endTest("registers");
    wb(fc_nsp_pkg::CTRL_ADDR, 1'b1, 32'h20);
    enTb = 1'b1;
    run <= 1'b1;
    repeat (80) @(posedge core_clk);
    run <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(fc_nsp_pkg::STATUS_ADDR, 32'h02, 32'h0B);
    lightOff <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd(fc_nsp_pkg::STATUS_ADDR, 32'h09, 32'h09);
    lightOff <= 1'b0;
    endTest("sync and light loss");
    wb(fc_nsp_pkg::REPLACE_CNT_ADDR, 1'b1, 32'h0);
    wb(fc_nsp_pkg::NOS_CNT_ADDR, 1'b1, 32'h0);
    for (int i = 0; i < 12; i++)
    begin
      w = {$urandom(), $urandom(), 2'h0};
      for (int c = 0; c < 4; c++) w[c*10 +: 10] = {w[c*10 +: 5], ~w[c*10 +: 5]};
      if (i % 4 == 1 || i % 4 == 2) w[9:0] = 10'h000;
      e = (i % 4 >= 2) ? 66'(fc_nsp_pkg::NOS_WORD_8B) :
          (i % 4 == 1) ? 66'({4{fc_nsp_pkg::K30_7_CHAR}}) : w;
      send(w, i % 4 == 2, i % 4 == 3, e, 66'hFF_FFFF_FFFF);
    end
    endTest("client words 8b10b");
    rd(fc_nsp_pkg::REPLACE_CNT_ADDR, 32'h3, 32'hFFFFFFFF);
    rd(fc_nsp_pkg::NOS_CNT_ADDR, 32'h6, 32'hFFFFFFFF);
    wb(fc_nsp_pkg::CTRL_ADDR, 1'b1, 32'h2C);
    for (int i = 0; i < 4; i++)
      send({$urandom(), $urandom(), 2'h3}, i[0], 1'b0, 66'(fc_nsp_pkg::HDR_CTRL), 66'h3);
    endTest("client words 64b66b");
    for (int r = 0; r < 8; r++)
    begin
      mode66 <= (r >= 4);
      wb(fc_nsp_pkg::CTRL_ADDR, 1'b1, 32'h20 | r);
      rateTb = 3'(r);
      run <= 1'b1;
      repeat (6)
      begin
        fecRxValid <= 1'b1;
        fecRxWord  <= {$urandom(), $urandom(), fc_nsp_pkg::HDR_DATA};
        @(posedge core_clk);
      end
      run        <= 1'b0;
      fecRxValid <= 1'b0;
      fecRxWord  <= ~fecRxWord;
      repeat (3) @(posedge core_clk);
    end
    endTest("every rate");
    wb(fc_nsp_pkg::CTRL_ADDR, 1'b1, 32'h0);
    enTb = 1'b0;
    run             <= 1'b1;
    iwfValid        <= 1'b1;
    packetLossState <= 1'b1;
    @(posedge core_clk);
    run <= 1'b0;
    endTest("disabled");
    check(66'(netQ.size() + txQ.size() + rdQ.size()), 66'h0);
    stop_test();
  end
endmodule : tb
bind fc_nsp fc_nsp_chk i_fc_nsp_chk (.*);
